/* File: src/rsc_pkg.sv */
package rsc_pkg;
    // ==========================================================
    // timing
    localparam int REF_CLK_MHZ = 50;
    localparam int POR_MIN_REF_CYCLES = 16;
    localparam int HARD_RELEASE_REF_CYCLES = 521;
    localparam int REF_MIN_MHZ = 10;
    localparam int REF_MAX_MHZ = 100;
    localparam int CORE_MAX_MHZ = 300;
    // 521 reference cycles are counted on ref_clk itself
    localparam int HARD_RELEASE_CYCLES = HARD_RELEASE_REF_CYCLES;
    localparam int CNT_W = 10;
    // ==========================================================
    // reset values
    localparam logic [1:0] BOOT_MODE_RST = 2'h0;
    // power-on flagged as the cause straight out of reset
    localparam logic [4:0] CAUSE_RST = 5'h10;

    typedef enum logic [1:0] {
        RSC_CLASS_NONE,
        RSC_CLASS_SOFT,
        RSC_CLASS_HARD,
        RSC_CLASS_POR
    } rsc_class_t;

    typedef struct packed {
        logic por_ext;
        logic hard_ext;
        logic watchdog;
        logic bus_monitor;
        logic test_soft;
    } rsc_src_t;

    // cause bits: power-on, external hard, watchdog, bus monitor, test
    typedef struct packed {
        logic power_on;
        logic hard_pin;
        logic watchdog;
        logic bus_monitor;
        logic soft_test;
    } rsc_cause_t;

    typedef struct packed {
        logic [1:0] boot_mode_select;
        logic watchdog_enable_strap;
        logic host_port_width_strap;
        logic host_data_strobe_polarity;
    } rsc_straps_t;

    typedef struct packed {
        logic pll_clk_synth;
        logic watchdog_busmon;
        logic stop_halt_logic;
        logic ext_core;
        logic peripherals;
    } rsc_actions_t;
endpackage

/* File: src/rsc_release_timer.sv */
`timescale 1ns/100ps
// ==========================================================
// counts down a fixed hold after start, busy meanwhile
module rsc_release_timer
    import rsc_pkg::*;
#(
    parameter int COUNT = HARD_RELEASE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic start,
    output logic busy
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic busy_q, busy_d;

    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        if (start) begin
            cnt_d = CNT_W'(COUNT - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy = busy_q;
endmodule // rsc_release_timer

/* File: src/rsc_reset_source_controller.sv */
`timescale 1ns/100ps
// How it works
// - power-on resets everything, drives hard pin
// - straps and PLL reset only on power-on
// - hard reset drives pin open-drain, resets core
// - enabled watchdog expiry starts hard reset
// - enabled bus monitor expiry starts hard reset
// - test boundary instructions start soft reset
// - status keeps causes of latest reset
// - sources map to classes; soft never drives pin
// - all classes reset watchdog and bus monitor
// - all classes reset stop/halt, core, peripherals
// - straps latched when power-on released
// - pin released 521 cycles after power-on
module rsc_reset_source_controller
    import rsc_pkg::*;
#(
    parameter int HARD_HOLD = HARD_RELEASE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // board side
    input wire logic power_on_reset_in,
    input wire logic hard_reset_pin_in,
    output logic hard_reset_pin_out,
    output logic hard_reset_pin_oe,
    input wire rsc_straps_t straps_in,
    // internal events
    input wire logic watchdog_zero,
    input wire logic watchdog_event_en,
    input wire logic bus_monitor_zero,
    input wire logic bus_monitor_event_en,
    input wire logic tap_boundary_instr,
    // results
    output rsc_actions_t actions,
    output rsc_straps_t straps_q,
    output rsc_cause_t cause_q,
    output rsc_class_t active_class
);
    // ==========================================================
    // source classification
    rsc_src_t src;
    rsc_class_t req_class;
    logic hard_busy;
    logic hard_start;
    logic pin_seen;

    // pin read back while we drive it low is our own echo
    assign pin_seen = hard_reset_pin_in && !hard_reset_pin_oe;

    always_comb begin
        src.por_ext = power_on_reset_in;
        src.hard_ext = pin_seen;
        src.watchdog = watchdog_zero && watchdog_event_en;
        src.bus_monitor = bus_monitor_zero && bus_monitor_event_en;
        src.test_soft = tap_boundary_instr;
        if (src.por_ext) begin
            req_class = RSC_CLASS_POR;
        end else if (src.hard_ext || src.watchdog || src.bus_monitor) begin
            req_class = RSC_CLASS_HARD;
        end else if (src.test_soft) begin
            req_class = RSC_CLASS_SOFT;
        end else begin
            req_class = RSC_CLASS_NONE;
        end
    end

    // ==========================================================
    // class state and pin hold
    rsc_class_t cls_q, cls_d;
    logic por_q, por_d;
    logic pin_oe_q, pin_oe_d;

    // the pin stays low for the hold after power-on release or a hard request
    assign hard_start = (por_q && !power_on_reset_in)
        || (req_class == RSC_CLASS_HARD && !hard_busy);

    // the registered pin enable adds the last cycle of the hold
    rsc_release_timer #(
        .COUNT(HARD_HOLD - 1)
    ) u_release (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(hard_start),
        .busy(hard_busy)
    );

    always_comb begin
        por_d = power_on_reset_in;
        cls_d = req_class;
        // a running hold keeps its class over idle or soft requests
        if ((req_class == RSC_CLASS_NONE || req_class == RSC_CLASS_SOFT)
            && (hard_busy || hard_start)) begin
            cls_d = (cls_q == RSC_CLASS_POR) ? RSC_CLASS_POR
                                             : RSC_CLASS_HARD;
        end
        // start term covers the edge before the timer turns busy
        pin_oe_d = power_on_reset_in || hard_busy || hard_start
            || src.watchdog || src.bus_monitor;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cls_q <= RSC_CLASS_POR;
            por_q <= 1'b1;
            pin_oe_q <= 1'b1;
        end else begin
            cls_q <= cls_d;
            por_q <= por_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // ==========================================================
    // straps, cause and actions
    rsc_straps_t straps_d;
    rsc_cause_t cause_d;
    rsc_actions_t act_q, act_d;

    always_comb begin
        straps_d = straps_q;
        if (por_q && !power_on_reset_in) begin
            straps_d = straps_in;
        end
        cause_d = cause_q;
        if (req_class != RSC_CLASS_NONE
            && (cls_q == RSC_CLASS_NONE || cls_q == RSC_CLASS_SOFT)) begin
            cause_d = '0;
        end
        if (src.por_ext) cause_d.power_on = 1'b1;
        if (src.hard_ext) cause_d.hard_pin = 1'b1;
        if (src.watchdog) cause_d.watchdog = 1'b1;
        if (src.bus_monitor) cause_d.bus_monitor = 1'b1;
        if (src.test_soft) cause_d.soft_test = 1'b1;
        act_d.pll_clk_synth = (cls_d == RSC_CLASS_POR);
        act_d.watchdog_busmon = (cls_d != RSC_CLASS_NONE);
        act_d.stop_halt_logic = (cls_d != RSC_CLASS_NONE);
        act_d.ext_core = (cls_d != RSC_CLASS_NONE);
        act_d.peripherals = (cls_d != RSC_CLASS_NONE);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            straps_q <= '0;
            cause_q <= rsc_cause_t'(CAUSE_RST);
            act_q <= '1;
        end else begin
            straps_q <= straps_d;
            cause_q <= cause_d;
            act_q <= act_d;
        end
    end

    assign actions = act_q;
    assign active_class = cls_q;
    assign hard_reset_pin_oe = pin_oe_q;
    assign hard_reset_pin_out = 1'b0;

    // ==========================================================
    // checks
    sequence s_por_release;
        por_q && !power_on_reset_in;
    endsequence

    sequence s_new_reset;
        cls_q == RSC_CLASS_NONE && req_class != RSC_CLASS_NONE;
    endsequence

    a_soft_no_pin: assert property (
        @(posedge ref_clk) disable iff (rst)
        (cls_q == RSC_CLASS_SOFT) |-> !hard_reset_pin_oe)
        else $error("soft reset drove hard pin");
    a_wdog_hard: assert property (
        @(posedge ref_clk) disable iff (rst)
        (watchdog_zero && watchdog_event_en) |=> (cls_q == RSC_CLASS_HARD
        || cls_q == RSC_CLASS_POR) && hard_reset_pin_oe)
        else $error("watchdog did not start hard reset");
    a_bmon_hard: assert property (
        @(posedge ref_clk) disable iff (rst)
        (bus_monitor_zero && bus_monitor_event_en) |=>
        hard_reset_pin_oe && cause_q.bus_monitor)
        else $error("bus monitor did not start hard reset");
    a_tap_soft: assert property (
        @(posedge ref_clk) disable iff (rst)
        tap_boundary_instr |=> cls_q != RSC_CLASS_NONE
        && cause_q.soft_test)
        else $error("test request ignored");
    a_strap_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(por_q && !power_on_reset_in) |=> $stable(straps_q))
        else $error("straps changed outside power-on");
    a_strap_take: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_por_release |=> straps_q == $past(straps_in))
        else $error("straps not latched");
    a_pin_release: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_por_release ##1 (!power_on_reset_in && req_class ==
        RSC_CLASS_NONE)[*8] |-> hard_reset_pin_oe)
        else $error("pin released too early");
    a_por_all: assert property (
        @(posedge ref_clk) disable iff (rst)
        power_on_reset_in |=> ##1 actions == '1)
        else $error("power-on actions incomplete");
    a_hard_core: assert property (
        @(posedge ref_clk) disable iff (rst)
        pin_seen |=> ##1 actions.ext_core && actions.watchdog_busmon
        && actions.stop_halt_logic)
        else $error("hard reset actions incomplete");
    a_por_class: assert property (
        @(posedge ref_clk) disable iff (rst)
        power_on_reset_in |=> cls_q == RSC_CLASS_POR
        && hard_reset_pin_oe)
        else $error("power-on did not take priority");
    a_pll_por_only: assert property (
        @(posedge ref_clk) disable iff (rst)
        cls_q != RSC_CLASS_POR |-> !actions.pll_clk_synth)
        else $error("clock synthesis reset outside power-on");
    a_soft_acts: assert property (
        @(posedge ref_clk) disable iff (rst)
        cls_q == RSC_CLASS_SOFT |-> actions.watchdog_busmon
        && actions.stop_halt_logic && actions.ext_core
        && actions.peripherals)
        else $error("soft reset actions incomplete");
    a_hard_over_soft: assert property (
        @(posedge ref_clk) disable iff (rst)
        hard_busy && tap_boundary_instr && !power_on_reset_in |=>
        cls_q == RSC_CLASS_HARD || cls_q == RSC_CLASS_POR)
        else $error("soft request displaced hard reset");
    a_cause_new: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_new_reset |=> cause_q == rsc_cause_t'($past(src)))
        else $error("reset cause not recorded");
endmodule // rsc_reset_source_controller

/* File: dv/rsc_board_model.sv */
`timescale 1ns/100ps
// ==========================================================
// board reset circuit and test port, driven at falling edge
module rsc_board_model
    import rsc_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // device pin side
    input wire logic hard_reset_pin_oe,
    output logic power_on_reset_in,
    output logic hard_reset_pin_in,
    // test port
    output logic tap_boundary_instr
);
    logic board_pull = 1'b0;
    // open drain: reads 1 when either side pulls, 0 when both release
    assign hard_reset_pin_in = board_pull | hard_reset_pin_oe;
    initial begin
        power_on_reset_in = 1'b1;
        tap_boundary_instr = 1'b0;
    end
    // ==========================================================
    // commands
    task automatic por(input int n);
        power_on_reset_in = 1'b1;
        // never shorter than the board minimum
        n = (n < POR_MIN_REF_CYCLES) ? POR_MIN_REF_CYCLES : n;
        repeat (n) @(negedge ref_clk);
        power_on_reset_in = 1'b0;
    endtask
    task automatic pin(input int n);
        board_pull = 1'b1;
        repeat (n) @(negedge ref_clk);
        board_pull = 1'b0;
    endtask
    task automatic tap(input int n);
        tap_boundary_instr = 1'b1;
        repeat (n) @(negedge ref_clk);
        tap_boundary_instr = 1'b0;
    endtask
endmodule // rsc_board_model

/* File: dv/tb.sv */
`timescale 1ns/100ps
// ==========================================================
// bench: board model drives power-on, pin and test port, notes checked in order
module tb
    import rsc_pkg::*;
;
    localparam int HOLD = 20;
    logic ref_clk, rst, watchdog_zero, watchdog_event_en;
    logic bus_monitor_zero, bus_monitor_event_en, tap_boundary_instr;
    logic power_on_reset_in, hard_reset_pin_in, hard_reset_pin_oe;
    logic [4:0] straps_exp;
    rsc_straps_t straps_in, straps_q;
    rsc_actions_t actions;
    rsc_cause_t cause_q;
    rsc_class_t active_class, last;
    logic [17:0] notes[$];
    logic [17:0] exp;
    logic [17:0] got, got_rst;
    int fail_count = 0;
    int check_count = 0;
    int seed = 34933;
    int n;

    rsc_reset_source_controller #(.HARD_HOLD(HOLD)) DUT (
        .ref_clk(ref_clk), .rst(rst),
        .power_on_reset_in(power_on_reset_in),
        .hard_reset_pin_in(hard_reset_pin_in), .hard_reset_pin_out(),
        .hard_reset_pin_oe(hard_reset_pin_oe), .straps_in(straps_in),
        .watchdog_zero(watchdog_zero),
        .watchdog_event_en(watchdog_event_en),
        .bus_monitor_zero(bus_monitor_zero),
        .bus_monitor_event_en(bus_monitor_event_en),
        .tap_boundary_instr(tap_boundary_instr), .actions(actions),
        .straps_q(straps_q), .cause_q(cause_q),
        .active_class(active_class));
    rsc_board_model board (
        .ref_clk(ref_clk), .hard_reset_pin_oe(hard_reset_pin_oe),
        .power_on_reset_in(power_on_reset_in),
        .hard_reset_pin_in(hard_reset_pin_in),
        .tap_boundary_instr(tap_boundary_instr));

    // 50 MHz sits inside the allowed reference range
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // helpers
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [17:0] note(input rsc_class_t c,
        input logic [4:0] cs, input logic [4:0] act, input logic oe);
        return {c, cs, act, straps_exp, oe};
    endfunction
    task automatic wait_none;
        repeat (3) @(negedge ref_clk);
        n = 0;
        while (active_class !== RSC_CLASS_NONE && n < 200) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 200) begin
            fail_count++;
            summarize();
        end
        repeat (4) @(negedge ref_clk);
    endtask
    // src: 0 watchdog, 1 bus monitor, 2 pin, 3 test, 4 test+watchdog
    task automatic hit(input int src, input rsc_class_t c,
        input logic [4:0] cs);
        notes.push_back(note(c, cs, 5'h0f, c == RSC_CLASS_HARD));
        notes.push_back(note(RSC_CLASS_NONE, cs, 5'h00, 1'b0));
        watchdog_zero = (src == 0 || src == 4);
        bus_monitor_zero = (src == 1);
        fork
            begin
                @(negedge ref_clk);
                watchdog_zero = 1'b0;
                bus_monitor_zero = 1'b0;
            end
            if (src == 2) board.pin(2);
            if (src >= 3) board.tap(6);
        join
        if (src == 0) begin
            // pin pulled while we already drive it: no new cause
            repeat (2) @(negedge ref_clk);
            board.pin(3);
        end
        wait_none();
        $display("test %0d done", src);
    endtask
    // ==========================================================
    // result watcher
    initial begin
        last = RSC_CLASS_POR;
        forever begin
            @(negedge ref_clk);
            if (rst === 1'b0 && active_class !== last) begin
                last = active_class;
                repeat (2) @(negedge ref_clk);
                exp = (notes.size() == 0) ? 18'h3_ffff : notes.pop_front();
                got = {active_class, cause_q, actions, straps_q,
                    hard_reset_pin_oe};
                check(got, exp);
            end
        end
    end
    // ==========================================================
    // stimulus
    initial begin
        rst = 1'b1;
        watchdog_zero = 1'b0;
        bus_monitor_zero = 1'b0;
        watchdog_event_en = 1'b1;
        bus_monitor_event_en = 1'b1;
        straps_exp = 5'($random(seed));
        straps_in = rsc_straps_t'(straps_exp);
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        got_rst = {active_class, cause_q, actions, straps_q,
            hard_reset_pin_oe};
        check(got_rst, {RSC_CLASS_POR, CAUSE_RST, 5'h1f, 5'h00, 1'b1});
        notes.push_back(note(RSC_CLASS_NONE, 5'h10, 5'h00, 1'b0));
        board.por(POR_MIN_REF_CYCLES);
        @(negedge ref_clk);
        straps_in = rsc_straps_t'(~straps_exp);
        n = 1;
        while (hard_reset_pin_oe === 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        // the edge that saw the release is counted as one
        check(n, HOLD + 1);
        wait_none();
        $display("test por done");
        watchdog_event_en = 1'b0;
        bus_monitor_event_en = 1'b0;
        watchdog_zero = 1'b1;
        bus_monitor_zero = 1'b1;
        repeat (4) @(negedge ref_clk);
        check(active_class, RSC_CLASS_NONE);
        watchdog_zero = 1'b0;
        bus_monitor_zero = 1'b0;
        watchdog_event_en = 1'b1;
        bus_monitor_event_en = 1'b1;
        @(negedge ref_clk);
        hit(0, RSC_CLASS_HARD, 5'h04);
        hit(1, RSC_CLASS_HARD, 5'h02);
        hit(2, RSC_CLASS_HARD, 5'h08);
        hit(3, RSC_CLASS_SOFT, 5'h01);
        hit(4, RSC_CLASS_HARD, 5'h05);
        summarize();
    end
endmodule // tb
